// [shared/profile_mod_cfg.svh]
// Notes on behaviour
// - Pins pick one of 2/4/8/16 modulation levels.
// - Sixteen profiles per channel; 1-15 at consecutive offsets.
// - Dedicated frequency, phase and amplitude words hold profile 0.
// - Frequency 32, phase 14, amplitude 10 bits, MSB-aligned in profile words.
// - Type field: off, amplitude, frequency, phase.
// - Level field: 2, 4, 8 or 16 levels.
// - Ramp field: off, pins 2-3, pin 3, auxiliary pins.
// - Auxiliary ramp forces single-bit serial port mode.
// - Ramp pin low means up, high means down.
// - Auxiliary pins never select profiles.
// - Ramps act on the 10-bit amplitude scaler.
// - Assignment field maps pins to channels per level.
// - Two-level: pin n drives channel n.
// - Four-level: six channel pairs, two pins each.
// - Eight-level: low assignment bits pick channel, pins 0-2.
// - Sixteen-level: low assignment bits pick channel, pins 0-3.
`ifndef PROFILE_MOD_CFG_SVH
`define PROFILE_MOD_CFG_SVH

// Register indices inside the global or a channel block; byte address is four times the index.
`define IDX_GLOBAL_ONE 5'h01
`define IDX_STATUS 5'h02
`define IDX_CHAN_FUNC 5'h03
`define IDX_FREQ0 5'h04
`define IDX_PHASE0 5'h05
`define IDX_AMP0 5'h06
`define IDX_PROF_FIRST 5'h0a
`define IDX_PROF_LAST 5'h18
`define IDX_PROF_BASE 5'h09

// Address split of the word address.
`define ADDR_GLOBAL_BIT 7
`define ADDR_CHAN 6:5
`define ADDR_IDX 4:0

// Field positions.
`define FLD_MOD_TYPE 23:22
`define FLD_SWEEP_EN 14
`define FLD_LEVEL 9:8
`define FLD_RAMP 11:10
`define FLD_PPC 14:12
`define FLD_PHASE_MSB 31:18
`define FLD_AMP_MSB 31:22
`define FLD_PHASE0 13:0
`define FLD_AMP0 9:0
`define STS_PINS 3:0
`define STS_AUX 6:4
`define STS_SERIAL_1BIT 7
`define STS_RAMP_VALID 11:8
`define STS_RAMP_DIR 15:12

// Register reset word and saturation limit of the checking counter.
`define RST_WORD 32'h0000_0000
`define QUIET_MAX 2'h2

`endif

// [shared/profile_mod_pkg.sv]
`default_nettype none
package profile_mod_pkg;
  typedef enum logic [1:0] {
    MOD_OFF = 2'h0, MOD_AMP = 2'h1, MOD_FREQ = 2'h2, MOD_PHASE = 2'h3
  } mod_type_t;
  typedef enum logic [1:0] {
    LVL_2 = 2'h0, LVL_4 = 2'h1, LVL_8 = 2'h2, LVL_16 = 2'h3
  } level_t;
  typedef enum logic [1:0] {
    RAMP_OFF = 2'h0, RAMP_PIN23 = 2'h1, RAMP_PIN3 = 2'h2, RAMP_AUX = 2'h3
  } ramp_src_t;
endpackage
`default_nettype wire

// [logic/profile_pin_modulation_selector.sv]
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "profile_mod_cfg.svh"
module profile_pin_modulation_selector #(
  parameter int ADDR_W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM register slave.
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Profile and auxiliary trigger pins.
  input wire logic [3:0] select_pin,
  input wire logic [2:0] serial_aux_pin,
  // Per-channel output words and ramp requests, and the serial width limit.
  output wire logic [3:0][31:0] chan_freq_word,
  output wire logic [3:0][13:0] chan_phase_word,
  output wire logic [3:0][9:0] chan_amp_word,
  output wire logic [3:0] amp_ramp_trigger_valid,
  output wire logic [3:0] amp_ramp_trigger,
  output logic serial_single_bit_mode
);

  localparam int MEM_WORDS = 64;

  // Byte-lane merge used by every writable register.
  function automatic logic [31:0] be_merge(input logic [31:0] old_word,
                                           input logic [31:0] new_word,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Channel pair of a four-level or pins 2/3 ramp setting: {valid, first, second}.
  function automatic logic [4:0] pair_of(input logic [2:0] cfg);
    unique case (cfg)
      3'h0: pair_of = {1'b1, 2'h0, 2'h1};
      3'h1: pair_of = {1'b1, 2'h0, 2'h2};
      3'h2: pair_of = {1'b1, 2'h0, 2'h3};
      3'h3: pair_of = {1'b1, 2'h1, 2'h2};
      3'h4: pair_of = {1'b1, 2'h1, 2'h3};
      3'h5: pair_of = {1'b1, 2'h2, 2'h3};
      default: pair_of = {1'b0, 2'h0, 2'h0};
    endcase
  endfunction

  // Profile chosen for one channel by the pins: {pins drive it, index}.
  // The lowest-numbered pin is the most significant bit of every multi-pin index.
  function automatic logic [4:0] pick_profile(input logic [1:0] ch,
                                              input logic [3:0] p,
                                              input profile_mod_pkg::level_t lvl,
                                              input logic [2:0] cfg,
                                              input profile_mod_pkg::ramp_src_t rsrc);
    logic [4:0] pr;
    pr = pair_of(cfg);
    pick_profile = 5'h00;
    if (rsrc == profile_mod_pkg::RAMP_PIN23) begin
      // Pins 2 and 3 are taken for ramping, so only two levels remain.
      if (pr[4] && ch == pr[3:2]) begin
        pick_profile = {1'b1, 3'h0, p[0]};
      end else if (pr[4] && ch == pr[1:0]) begin
        pick_profile = {1'b1, 3'h0, p[1]};
      end
    end else if (rsrc == profile_mod_pkg::RAMP_PIN3 || lvl == profile_mod_pkg::LVL_8) begin
      if (ch == cfg[1:0]) begin
        pick_profile = {1'b1, 1'b0, p[0], p[1], p[2]};
      end
    end else if (lvl == profile_mod_pkg::LVL_2) begin
      pick_profile = {1'b1, 3'h0, p[ch]};
    end else if (lvl == profile_mod_pkg::LVL_4) begin
      if (pr[4] && ch == pr[3:2]) begin
        pick_profile = {1'b1, 2'h0, p[0], p[1]};
      end else if (pr[4] && ch == pr[1:0]) begin
        pick_profile = {1'b1, 2'h0, p[2], p[3]};
      end
    end else if (ch == cfg[1:0]) begin
      pick_profile = {1'b1, p[0], p[1], p[2], p[3]};
    end
  endfunction

  // Ramp request for one channel: {channel has a trigger, 1 for down}.
  function automatic logic [1:0] pick_ramp(input logic [1:0] ch,
                                           input logic [3:0] p,
                                           input logic [2:0] aux,
                                           input profile_mod_pkg::level_t lvl,
                                           input logic [2:0] cfg,
                                           input profile_mod_pkg::ramp_src_t rsrc);
    logic [4:0] pr;
    pr = pair_of(cfg);
    pick_ramp = 2'h0;
    unique case (rsrc)
      profile_mod_pkg::RAMP_OFF: pick_ramp = 2'h0;
      profile_mod_pkg::RAMP_PIN23: begin
        if (pr[4] && ch == pr[3:2]) begin
          pick_ramp = {1'b1, p[2]};
        end else if (pr[4] && ch == pr[1:0]) begin
          pick_ramp = {1'b1, p[3]};
        end
      end
      profile_mod_pkg::RAMP_PIN3: begin
        if (ch == cfg[1:0]) begin
          pick_ramp = {1'b1, p[3]};
        end
      end
      profile_mod_pkg::RAMP_AUX: begin
        if (lvl == profile_mod_pkg::LVL_2) begin
          // Aux pins 1 and 2 address the channel, aux pin 3 gives the direction.
          if (ch == {aux[0], aux[1]}) begin
            pick_ramp = {1'b1, aux[2]};
          end
        end else if (lvl == profile_mod_pkg::LVL_4) begin
          if (pr[4] && ch == pr[3:2]) begin
            pick_ramp = {1'b1, aux[0]};
          end else if (pr[4] && ch == pr[1:0]) begin
            pick_ramp = {1'b1, aux[1]};
          end
        end else if (ch == cfg[1:0]) begin
          pick_ramp = {1'b1, aux[0]};
        end
      end
    endcase
  endfunction

  // Two-stage synchronisers; the first stage feeds only the second.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [2:0] aux_meta;
  logic [2:0] aux_sync;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      aux_meta <= 3'h0;
      aux_sync <= 3'h0;
    end else begin
      pin_meta <= select_pin;
      pin_sync <= pin_meta;
      aux_meta <= serial_aux_pin;
      aux_sync <= aux_meta;
    end
  end

  // Configuration and profile storage.
  profile_mod_pkg::level_t level_sel;
  profile_mod_pkg::ramp_src_t ramp_src;
  logic [2:0] pin_assign_config;
  profile_mod_pkg::mod_type_t mod_type_select [4];
  logic sweep_en [4];
  logic [31:0] freq0 [4];
  logic [13:0] phase0 [4];
  logic [9:0] amp0 [4];
  logic [31:0] prof_mem [MEM_WORDS];
  logic [3:0] ramp_valid;
  logic [3:0] ramp_dir;

  // Address decode; unmapped words read zero and ignore writes.
  wire logic [7:0] word_addr = address[9:2];
  wire logic is_global = word_addr[`ADDR_GLOBAL_BIT];
  wire logic [1:0] dec_ch = word_addr[`ADDR_CHAN];
  wire logic [4:0] dec_idx = word_addr[`ADDR_IDX];
  wire logic is_prof = !is_global && dec_idx >= `IDX_PROF_FIRST && dec_idx <= `IDX_PROF_LAST;
  wire logic [3:0] dec_prof = 4'(dec_idx - `IDX_PROF_BASE);
  wire logic [5:0] mem_addr = {dec_ch, dec_prof};
  wire logic wr_glob = write && is_global && dec_idx == `IDX_GLOBAL_ONE;
  wire logic wr_prof = write && is_prof;

  // Register views as software sees them.
  logic [31:0] glob_view;
  logic [31:0] status_view;
  logic [31:0] cfr_view;
  always_comb begin
    glob_view = `RST_WORD;
    glob_view[`FLD_LEVEL] = level_sel;
    glob_view[`FLD_RAMP] = ramp_src;
    glob_view[`FLD_PPC] = pin_assign_config;
    status_view = `RST_WORD;
    status_view[`STS_PINS] = pin_sync;
    status_view[`STS_AUX] = aux_sync;
    status_view[`STS_SERIAL_1BIT] = serial_single_bit_mode;
    status_view[`STS_RAMP_VALID] = ramp_valid;
    status_view[`STS_RAMP_DIR] = ramp_dir;
    cfr_view = `RST_WORD;
    cfr_view[`FLD_MOD_TYPE] = mod_type_select[dec_ch];
    cfr_view[`FLD_SWEEP_EN] = sweep_en[dec_ch];
  end

  wire logic [31:0] freq0_view = freq0[dec_ch];
  wire logic [31:0] phase0_view = {18'h0_0000, phase0[dec_ch]};
  wire logic [31:0] amp0_view = {22'h00_0000, amp0[dec_ch]};
  wire logic [31:0] glob_new = be_merge(glob_view, writedata, byteenable);
  wire logic [31:0] cfr_new = be_merge(cfr_view, writedata, byteenable);
  wire logic [31:0] freq0_new = be_merge(freq0_view, writedata, byteenable);
  wire logic [31:0] phase0_new = be_merge(phase0_view, writedata, byteenable);
  wire logic [31:0] amp0_new = be_merge(amp0_view, writedata, byteenable);
  wire logic [31:0] prof_new = be_merge(prof_mem[mem_addr], writedata, byteenable);

  // Read selection.
  wire logic [31:0] chan_rd = is_prof ? prof_mem[mem_addr] :
                              dec_idx == `IDX_CHAN_FUNC ? cfr_view :
                              dec_idx == `IDX_FREQ0 ? freq0_view :
                              dec_idx == `IDX_PHASE0 ? phase0_view :
                              dec_idx == `IDX_AMP0 ? amp0_view : `RST_WORD;
  wire logic [31:0] glob_rd = dec_idx == `IDX_GLOBAL_ONE ? glob_view :
                              dec_idx == `IDX_STATUS ? status_view : `RST_WORD;
  wire logic [31:0] rd_mux = is_global ? glob_rd : chan_rd;

  // Reads wait one cycle so readdata comes from a flop; writes never wait.
  logic rd_ack;
  assign waitrequest = read && !rd_ack;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack <= 1'b0;
      readdata <= `RST_WORD;
    end else begin
      rd_ack <= read && !rd_ack;
      if (read && !rd_ack) begin
        readdata <= rd_mux;
      end
    end
  end

  // Global configuration; the serial width limit follows the ramp source.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_sel <= profile_mod_pkg::LVL_2;
      ramp_src <= profile_mod_pkg::RAMP_OFF;
      pin_assign_config <= 3'h0;
      serial_single_bit_mode <= 1'b0;
    end else begin
      if (wr_glob) begin
        level_sel <= profile_mod_pkg::level_t'(glob_new[`FLD_LEVEL]);
        ramp_src <= profile_mod_pkg::ramp_src_t'(glob_new[`FLD_RAMP]);
        pin_assign_config <= glob_new[`FLD_PPC];
      end
      serial_single_bit_mode <= ramp_src == profile_mod_pkg::RAMP_AUX;
    end
  end

  // Profile words 1 to 15 of all channels; slot 0 of each channel is unused.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        prof_mem[i] <= `RST_WORD;
      end
    end else if (wr_prof) begin
      prof_mem[mem_addr] <= prof_new;
    end
  end

  // Per-channel registers, selection and output flops.
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [31:0] out_freq;
    logic [13:0] out_phase;
    logic [9:0] out_amp;
    wire logic hit = write && !is_global && dec_ch == 2'(c);
    wire logic [4:0] sel = pick_profile(2'(c), pin_sync, level_sel,
                                        pin_assign_config, ramp_src);
    wire logic [1:0] rmp = pick_ramp(2'(c), pin_sync, aux_sync, level_sel,
                                     pin_assign_config, ramp_src);
    wire logic use_prof = sel[4] && sel[3:0] != 4'h0 &&
                          mod_type_select[c] != profile_mod_pkg::MOD_OFF;
    wire logic [31:0] word = prof_mem[{2'(c), sel[3:0]}];
    // Only the modulated quantity takes the profile word; the rest stay at profile 0.
    wire logic [31:0] next_freq =
      use_prof && mod_type_select[c] == profile_mod_pkg::MOD_FREQ ? word : freq0[c];
    wire logic [13:0] next_phase =
      use_prof && mod_type_select[c] == profile_mod_pkg::MOD_PHASE ?
      word[`FLD_PHASE_MSB] : phase0[c];
    wire logic [9:0] next_amp =
      use_prof && mod_type_select[c] == profile_mod_pkg::MOD_AMP ?
      word[`FLD_AMP_MSB] : amp0[c];

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mod_type_select[c] <= profile_mod_pkg::MOD_OFF;
        sweep_en[c] <= 1'b0;
        freq0[c] <= `RST_WORD;
        phase0[c] <= 14'h0000;
        amp0[c] <= 10'h000;
      end else if (hit) begin
        if (dec_idx == `IDX_CHAN_FUNC) begin
          mod_type_select[c] <= profile_mod_pkg::mod_type_t'(cfr_new[`FLD_MOD_TYPE]);
          sweep_en[c] <= cfr_new[`FLD_SWEEP_EN];
        end
        if (dec_idx == `IDX_FREQ0) freq0[c] <= freq0_new;
        if (dec_idx == `IDX_PHASE0) phase0[c] <= phase0_new[`FLD_PHASE0];
        if (dec_idx == `IDX_AMP0) amp0[c] <= amp0_new[`FLD_AMP0];
      end
    end

    // Every channel sees the same two sync stages plus this flop.
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        out_freq <= `RST_WORD;
        out_phase <= 14'h0000;
        out_amp <= 10'h000;
        ramp_valid[c] <= 1'b0;
        ramp_dir[c] <= 1'b0;
      end else begin
        out_freq <= next_freq;
        out_phase <= next_phase;
        out_amp <= next_amp;
        ramp_valid[c] <= rmp[1];
        ramp_dir[c] <= rmp[0];
      end
    end

    assign chan_freq_word[c] = out_freq;
    assign chan_phase_word[c] = out_phase;
    assign chan_amp_word[c] = out_amp;
  end

  assign amp_ramp_trigger_valid = ramp_valid;
  assign amp_ramp_trigger = ramp_dir;

  // Checking helpers: cycles since the last register write, saturating.
  logic [1:0] quiet;
  wire logic [3:0] pins_msb_first = {select_pin[0], select_pin[1], select_pin[2], select_pin[3]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet <= 2'h0;
    end else begin
      quiet <= write ? 2'h0 : (quiet == `QUIET_MAX ? quiet : quiet + 2'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_two_level_pin: assert property (
    quiet != 2'h0 && level_sel == profile_mod_pkg::LVL_2 &&
    ramp_src == profile_mod_pkg::RAMP_OFF &&
    mod_type_select[0] == profile_mod_pkg::MOD_FREQ |->
    chan_freq_word[0] == ($past(select_pin[0], 3) ? prof_mem[1] : freq0[0]))
    else $error("two-level pin 0 did not pick the right frequency word");

  a_off_dedicated_words: assert property (
    quiet != 2'h0 && mod_type_select[1] == profile_mod_pkg::MOD_OFF |->
    chan_freq_word[1] == freq0[1] && chan_phase_word[1] == phase0[1] &&
    chan_amp_word[1] == amp0[1])
    else $error("disabled channel left its dedicated words");

  a_sixteen_phase_msb: assert property (
    quiet != 2'h0 && level_sel == profile_mod_pkg::LVL_16 &&
    ramp_src == profile_mod_pkg::RAMP_OFF && pin_assign_config[1:0] == 2'h2 &&
    mod_type_select[2] == profile_mod_pkg::MOD_PHASE && $past(pins_msb_first, 3) != 4'h0 |->
    chan_phase_word[2] == prof_mem[{2'h2, $past(pins_msb_first, 3)}][`FLD_PHASE_MSB])
    else $error("sixteen-level phase word not taken from upper bits");

  a_four_level_pair: assert property (
    quiet != 2'h0 && level_sel == profile_mod_pkg::LVL_4 &&
    ramp_src == profile_mod_pkg::RAMP_OFF && pin_assign_config == 3'h2 &&
    mod_type_select[3] == profile_mod_pkg::MOD_AMP |->
    chan_amp_word[3] == ($past(pins_msb_first[1:0], 3) == 2'h0 ? amp0[3] :
      prof_mem[{2'h3, 2'h0, $past(pins_msb_first[1:0], 3)}][`FLD_AMP_MSB]))
    else $error("four-level second channel used the wrong pins");

  a_eight_level_index: assert property (
    quiet != 2'h0 && level_sel == profile_mod_pkg::LVL_8 &&
    ramp_src == profile_mod_pkg::RAMP_OFF && pin_assign_config == 3'h6 &&
    mod_type_select[2] == profile_mod_pkg::MOD_FREQ |->
    chan_freq_word[2] == ($past(pins_msb_first[3:1], 3) == 3'h0 ? freq0[2] :
      prof_mem[{2'h2, 1'b0, $past(pins_msb_first[3:1], 3)}]))
    else $error("eight-level index or channel choice wrong");

  a_ramp_pin_polarity: assert property (
    quiet != 2'h0 && ramp_src == profile_mod_pkg::RAMP_PIN3 &&
    pin_assign_config[1:0] == 2'h1 |->
    amp_ramp_trigger_valid[1] && amp_ramp_trigger[1] == $past(select_pin[3], 3))
    else $error("pin 3 ramp direction wrong");

  a_ramp_off_quiet: assert property (
    quiet != 2'h0 && ramp_src == profile_mod_pkg::RAMP_OFF |-> amp_ramp_trigger_valid == 4'h0)
    else $error("ramp trigger active while ramping disabled");

  a_aux_no_profile: assert property (
    quiet == `QUIET_MAX && ramp_src == profile_mod_pkg::RAMP_AUX &&
    $past(select_pin, 3) == $past(select_pin, 4) |-> $stable(chan_freq_word[0]))
    else $error("auxiliary pins changed a profile choice");

  a_serial_single_bit: assert property (
    quiet != 2'h0 |-> serial_single_bit_mode == (ramp_src == profile_mod_pkg::RAMP_AUX))
    else $error("serial width limit does not follow ramp source");

  c_sixteen_level: cover property (level_sel == profile_mod_pkg::LVL_16 &&
    mod_type_select[3] == profile_mod_pkg::MOD_FREQ && pin_sync == 4'hf);
  c_four_level_pair: cover property (level_sel == profile_mod_pkg::LVL_4 &&
    mod_type_select[0] != profile_mod_pkg::MOD_OFF && pin_sync != 4'h0);
  c_aux_ramp_down: cover property (ramp_src == profile_mod_pkg::RAMP_AUX && ramp_dir != 4'h0);
  c_read_done: cover property (read && waitrequest ##1 read && !waitrequest);

endmodule
`default_nettype wire

// [sim/pin_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_controller_model (
  // Clock.
  input wire logic clk,
  // Levels commanded by the bench.
  input wire logic [3:0] want_pins,
  input wire logic [2:0] want_aux,
  // Pins toward the device.
  output logic [3:0] select_pin,
  output logic [2:0] serial_aux_pin
);
  // Start from a known level so the synchronisers never see an unknown.
  initial begin
    select_pin = 4'h0;
    serial_aux_pin = 3'h0;
  end

  // A synchronous controller moves its pins only just after an edge.
  always @(posedge clk) begin
    select_pin <= want_pins;
    serial_aux_pin <= want_aux;
  end
endmodule
`default_nettype wire

// [sim/profile_pin_modulation_selector_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module profile_pin_modulation_selector_tb;
  logic clk, rst_b, read, write, waitrequest, serial_single_bit_mode;
  logic [9:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable, want_pins, select_pin, amp_ramp_trigger_valid, amp_ramp_trigger, q;
  logic [2:0] want_aux, serial_aux_pin, x;
  logic [3:0][31:0] chan_freq_word;
  logic [3:0][13:0] chan_phase_word;
  logic [3:0][9:0] chan_amp_word;
  logic [3:0] ei [4];
  profile_mod_pkg::mod_type_t et [4];
  profile_mod_pkg::mod_type_t tt [4];
  int fails, n_checks;
  int fa [6] = '{0, 0, 0, 1, 1, 2};
  int sb [6] = '{1, 2, 3, 2, 3, 3};

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  profile_pin_modulation_selector u_dut (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .select_pin(select_pin),
    .serial_aux_pin(serial_aux_pin), .chan_freq_word(chan_freq_word),
    .chan_phase_word(chan_phase_word), .chan_amp_word(chan_amp_word),
    .amp_ramp_trigger_valid(amp_ramp_trigger_valid), .amp_ramp_trigger(amp_ramp_trigger),
    .serial_single_bit_mode(serial_single_bit_mode));

  pin_controller_model u_ctl (.clk(clk), .want_pins(want_pins), .want_aux(want_aux),
    .select_pin(select_pin), .serial_aux_pin(serial_aux_pin));

  // A profile word that differs in every channel and index, so a wrong pick shows.
  function automatic logic [31:0] pv(input int c, input int k);
    pv = {4'(k), 4'(c), 8'h3c, 4'(k), 4'(c), 8'hc3};
  endfunction

  function automatic logic [9:0] ra(input int c, input int idx);
    ra = {1'b0, 2'(c), 5'(idx), 2'b00};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus cycles: waitrequest is judged at the rising edge, before any flop there has moved.
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg(input logic [1:0] l, input logic [1:0] r, input logic [2:0] s);
    bus_wr(10'h204, {17'h0_0000, s, r, l, 8'h00}, 4'hf);
  endtask

  // Sweep enable is left at zero whenever pin modulation is used.
  task automatic set_ty(input int c, input profile_mod_pkg::mod_type_t t);
    bus_wr(ra(c, 3), {8'h00, t, 22'h00_0000}, 4'hf);
    et[c] = t;
  endtask

  // Drive pins, let them pass the synchronisers, then judge every output.
  task automatic go(input logic [3:0] p, input logic [2:0] a, input logic [3:0] rv,
                    input logic [3:0] rdir, input logic sm);
    logic [31:0] w, w0;
    logic m;
    want_pins <= p;
    want_aux <= a;
    repeat (6) @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 4; c++) begin
      m = (et[c] != profile_mod_pkg::MOD_OFF) && (ei[c] != 4'h0);
      w = pv(c, m ? int'(ei[c]) : 0);
      w0 = pv(c, 0);
      chk("freq_word", (m && et[c] == profile_mod_pkg::MOD_FREQ) ? w : w0,
          chan_freq_word[c]);
      chk("phase_word", 32'((m && et[c] == profile_mod_pkg::MOD_PHASE) ? w[31:18] : w0[13:0]),
          32'(chan_phase_word[c]));
      chk("amp_word", 32'((m && et[c] == profile_mod_pkg::MOD_AMP) ? w[31:22] : w0[9:0]),
          32'(chan_amp_word[c]));
    end
    chk("ramp_valid", 32'(rv), 32'(amp_ramp_trigger_valid));
    chk("ramp_dir", 32'(rdir), 32'(amp_ramp_trigger & rv));
    chk("single_bit", 32'(sm), 32'(serial_single_bit_mode));
    @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end

  // Main sequence.
  initial begin
    rst_b = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    byteenable = 4'hf; want_pins = 4'h0; want_aux = 3'h0; fails = 0; n_checks = 0;
    tt = '{profile_mod_pkg::MOD_FREQ, profile_mod_pkg::MOD_AMP,
           profile_mod_pkg::MOD_PHASE, profile_mod_pkg::MOD_FREQ};
    for (int c = 0; c < 4; c++) begin
      ei[c] = 4'h0;
      et[c] = profile_mod_pkg::MOD_OFF;
    end
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus_rd(ra(0, 4), rd);
    chk("freq0_reset", 32'h0000_0000, rd);
    // Load profile 0 into the dedicated words and 1 to 15 into the profile block.
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 16; k++) bus_wr(ra(c, (k == 0) ? 4 : 9 + k), pv(c, k), 4'hf);
      bus_wr(ra(c, 5), pv(c, 0), 4'hf);
      bus_wr(ra(c, 6), pv(c, 0), 4'hf);
    end
    bus_rd(ra(1, 24), rd);
    chk("profile15", pv(1, 15), rd);
    bus_rd(ra(2, 5), rd);
    chk("phase0", pv(2, 0) & 32'h0000_3fff, rd);
    bus_rd(ra(3, 6), rd);
    chk("amp0", pv(3, 0) & 32'h0000_03ff, rd);
    bus_wr(ra(0, 31), 32'hffff_ffff, 4'hf);
    bus_rd(ra(0, 31), rd);
    chk("unmapped", 32'h0000_0000, rd);
    bus_wr(ra(0, 10), 32'hffff_ffff, 4'h1);
    bus_rd(ra(0, 10), rd);
    chk("lane_merge", pv(0, 1) | 32'h0000_00ff, rd);
    bus_wr(ra(0, 10), pv(0, 1), 4'hf);
    // Two levels: pin n drives channel n whatever the assignment holds.
    cfg(2'h0, 2'h0, 3'h7);
    for (int c = 0; c < 4; c++) set_ty(c, profile_mod_pkg::MOD_FREQ);
    for (int p = 0; p < 16; p++) begin
      q = 4'(p);
      for (int c = 0; c < 4; c++) ei[c] = {3'h0, q[c]};
      go(q, 3'h0, 4'h0, 4'h0, 1'b0);
    end
    // Four levels over every channel pair; unpaired channels are turned off.
    for (int s = 0; s < 6; s++) begin
      cfg(2'h1, 2'h0, 3'(s));
      for (int c = 0; c < 4; c++)
        set_ty(c, (c == fa[s]) ? profile_mod_pkg::MOD_FREQ :
                  (c == sb[s]) ? profile_mod_pkg::MOD_AMP : profile_mod_pkg::MOD_OFF);
      q = 4'hd ^ 4'(s);
      ei[fa[s]] = {2'h0, q[0], q[1]};
      ei[sb[s]] = {2'h0, q[2], q[3]};
      go(q, 3'h0, 4'h0, 4'h0, 1'b0);
    end
    // Eight and sixteen levels with the ignored top assignment bit set.
    for (int c = 0; c < 4; c++) begin
      cfg(2'h2, 2'h0, 3'(4 + c));
      for (int d = 0; d < 4; d++)
        set_ty(d, (d == c) ? profile_mod_pkg::MOD_FREQ : profile_mod_pkg::MOD_OFF);
      for (int j = 0; j < 2; j++) begin
        q = {1'(j), 3'(c + 3)};
        ei[c] = {1'b0, q[0], q[1], q[2]};
        go(q, 3'h0, 4'h0, 4'h0, 1'b0);
      end
      cfg(2'h3, 2'h0, 3'(4 + c));
      set_ty(c, tt[c]);
      for (int p = 0; p < 16; p++) begin
        q = 4'(p);
        ei[c] = {q[0], q[1], q[2], q[3]};
        go(q, 3'h0, 4'h0, 4'h0, 1'b0);
      end
    end
    // Ramp on pins 2 and 3 for the pair 0/3.
    cfg(2'h0, 2'h1, 3'h2);
    for (int c = 0; c < 4; c++)
      set_ty(c, (c == 0 || c == 3) ? profile_mod_pkg::MOD_FREQ : profile_mod_pkg::MOD_OFF);
    for (int p = 0; p < 16; p++) begin
      q = 4'(p);
      ei[0] = {3'h0, q[0]};
      ei[3] = {3'h0, q[1]};
      go(q, 3'h0, 4'h9, {q[3], 2'h0, q[2]}, 1'b0);
    end
    // Ramp on pin 3 forces eight levels on the assigned channel.
    cfg(2'h3, 2'h2, 3'h1);
    for (int c = 0; c < 4; c++)
      set_ty(c, (c == 1) ? profile_mod_pkg::MOD_FREQ : profile_mod_pkg::MOD_OFF);
    for (int p = 0; p < 16; p++) begin
      q = 4'(p);
      ei[1] = {1'b0, q[0], q[1], q[2]};
      go(q, 3'h0, 4'h2, {2'h0, q[3], 1'b0}, 1'b0);
    end
    // Auxiliary ramp pins: never a profile source, and the serial port narrows.
    cfg(2'h0, 2'h3, 3'h0);
    for (int c = 0; c < 4; c++) set_ty(c, profile_mod_pkg::MOD_FREQ);
    q = 4'h5;
    for (int c = 0; c < 4; c++) ei[c] = {3'h0, q[c]};
    for (int a = 0; a < 8; a++) begin
      x = 3'(a);
      go(q, x, 4'h1 << {x[0], x[1]}, x[2] ? 4'h1 << {x[0], x[1]} : 4'h0, 1'b1);
    end
    cfg(2'h0, 2'h0, 3'h0);
    go(q, 3'h7, 4'h0, 4'h0, 1'b0);
    // Auxiliary ramp with four levels: the first channel of the pair takes aux pin 1.
    cfg(2'h1, 2'h3, 3'h3);
    for (int c = 0; c < 4; c++)
      set_ty(c, (c == 1 || c == 2) ? profile_mod_pkg::MOD_FREQ : profile_mod_pkg::MOD_OFF);
    ei[1] = 4'h2;
    ei[2] = 4'h2;
    go(4'h5, 3'h2, 4'h6, 4'h4, 1'b1);
    // A second reset mid-run must clear stored words and the serial width limit.
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("single_bit_reset", 32'h0000_0000, 32'(serial_single_bit_mode));
    bus_rd(ra(2, 10), rd);
    chk("profile_after_reset", 32'h0000_0000, rd);
    close_out();
  end
endmodule
`default_nettype wire
